// >>> momc_host.sv
`timescale 1ns/1ps
`default_nettype none
module momc_host
(
  output logic sclk, // Serial clock
  output logic cs_n, // Select, active low
  output logic mosi, // Data to device
  input wire logic miso // Data from device
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b0;
    mosi = 1'b0;
    // Clean select rise clears the frame state
    #1 cs_n = 1'b1;
  end
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic xfer(input logic [23:0] hdr, input logic crc_on,
    input logic [7:0] wcrc, output logic [7:0] rd, output logic [7:0] rc);
    logic [31:0] sh;
    sh = {hdr, wcrc};
    rd = 8'h00;
    rc = 8'h00;
    cs_n = 1'b0;
    #105;
    for (int i = 0; i < (crc_on ? 32 : 24); i++)
    begin
      mosi = sh[31-i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
      if (i >= 15 && i <= 22)
        rd = {rd[6:0], miso};
      if (i >= 23 && i <= 30)
        rc = {rc[6:0], miso};
    end
    #7.5 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule
`default_nettype wire

// >>> momc_link.sv
`timescale 1ns/1ps
`default_nettype none
module momc_link
  import momc_pkg::*;
(
  input wire logic sclk, // Serial clock from host
  input wire logic cs_n, // Frame select, active low
  input wire logic mosi, // Host to device data
  input wire logic crc_en, // Check byte enable, stable in frame
  input wire logic [7:0] rd_op1, // Snapshot of first mode register
  input wire logic [7:0] rd_op2, // Snapshot of second mode register
  output logic miso, // Device to host data
  output logic miso_oe, // Drive enable for miso
  output logic wr_valid, // Frame carried a good write
  output logic crc_fail, // Write check byte mismatched
  output logic [ADDR_W-1:0] wr_addr, // Write address
  output logic [DATA_W-1:0] wr_data // Write data
);

  typedef struct packed {
    logic past;
    logic [4:0] edge_cnt;
    logic [7:0] shreg;
    logic [7:0] crc;
    logic [7:0] out_sh;
    logic is_wr;
    logic [ADDR_W-1:0] addr;
    logic miso;
    logic oe;
  } momc_frame_t;

  typedef struct packed {
    logic valid;
    logic fail;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } momc_result_t;

  momc_frame_t f;
  momc_frame_t next_f;
  momc_result_t r;
  momc_result_t next_r;

  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic b);
    logic fb;
    fb = c[7] ^ b;
    crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] rd_lookup(input logic [ADDR_W-1:0] a,
                                           input logic [7:0] v1,
                                           input logic [7:0] v2);
    case (a)
      OPM1_ADDR: rd_lookup = v1 & OPM1_MASK;
      OPM2_ADDR: rd_lookup = v2 & OPM2_MASK;
      default: rd_lookup = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: sample on rising edge, drive miso on rising edge
  always_comb
  begin
    logic bit_now;
    logic [7:0] byte_in;
    logic [7:0] crc_full;
    logic [7:0] rd;
    logic [ADDR_W-1:0] addr_full;
    next_f = f;
    next_r = r;
    bit_now = mosi;
    byte_in = {f.shreg[6:0], mosi};
    addr_full = {f.addr[ADDR_W-1:8], byte_in};
    rd = rd_lookup(addr_full, rd_op1, rd_op2);
    if (!f.is_wr && f.edge_cnt > EDGE_ADDR_DONE &&
        f.edge_cnt <= EDGE_DATA_DONE)
    begin
      bit_now = f.miso;
    end
    crc_full = crc_step(f.crc, bit_now);
    if (!f.past)
    begin
      next_f.shreg = byte_in;
      next_f.oe = 1'b1;
      next_f.miso = f.out_sh[7];
      next_f.out_sh = {f.out_sh[6:0], 1'b0};
      if (f.edge_cnt <= EDGE_DATA_DONE)
      begin
        next_f.crc = crc_full;
      end
      if (f.edge_cnt == 5'h00)
      begin
        next_f.is_wr = mosi;
        next_r.valid = 1'b0;
        next_r.fail = 1'b0;
      end
      if (f.edge_cnt == EDGE_CMD_DONE)
      begin
        next_f.addr[ADDR_W-1:8] = byte_in[ADDR_W-9:0];
      end
      if (f.edge_cnt == EDGE_ADDR_DONE)
      begin
        next_f.addr = addr_full;
        next_f.miso = rd[7];
        next_f.out_sh = {rd[6:0], 1'b0};
      end
      if (f.edge_cnt == EDGE_DATA_DONE)
      begin
        next_f.miso = crc_en & crc_full[7];
        next_f.out_sh = crc_en ? {crc_full[6:0], 1'b0} : 8'h00;
        if (f.is_wr)
        begin
          next_r.addr = f.addr;
          next_r.data = byte_in;
          next_r.valid = !crc_en;
        end
      end
      if (f.edge_cnt == EDGE_CRC_DONE && f.is_wr && crc_en)
      begin
        next_r.valid = (byte_in == f.crc);
        next_r.fail = (byte_in != f.crc);
        next_f.past = 1'b1;
      end
      else if (f.edge_cnt == EDGE_CRC_DONE)
      begin
        next_f.past = 1'b1;
      end
      next_f.edge_cnt = f.edge_cnt + 5'h01;
    end
  end

  // Frame state is cleared whenever the frame is closed
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      f <= '0;
    end
    else
    begin
      f <= next_f;
    end
  end

  // Result is held across the idle gap for the system side
  always_ff @(posedge sclk)
  begin
    r <= next_r;
  end

  assign miso = f.miso;
  assign miso_oe = f.oe;
  assign wr_valid = r.valid;
  assign crc_fail = r.fail;
  assign wr_addr = r.addr;
  assign wr_data = r.data;

endmodule
`default_nettype wire

// >>> momc_pkg.sv
package momc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OPM1_ADDR = 12'h002;
  localparam logic [ADDR_W-1:0] OPM2_ADDR = 12'h003;
  localparam logic [DATA_W-1:0] OPM1_RESET = 8'h00;
  localparam logic [DATA_W-1:0] OPM2_RESET = 8'h00;
  localparam logic [DATA_W-1:0] OPM1_MASK = 8'h0C;
  localparam logic [DATA_W-1:0] OPM2_MASK = 8'h77;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int OPM1_CRC_BIT = 3;
  localparam int OPM1_POL_BIT = 2;
  localparam int OPM2_HARM_BIT = 6;
  localparam int OPM2_FUNA_BIT = 5;
  localparam int OPM2_FUN_BIT = 4;
  localparam int OPM2_WIR_MSB = 2;
  localparam int OPM2_WIR_LSB = 1;
  localparam int OPM2_APP_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Wiring systems and power coefficients, unsigned Q1.15
  localparam logic [1:0] WIR_1P3W = 2'h0;
  localparam logic [1:0] WIR_3P3W = 2'h1;
  localparam logic [1:0] WIR_3V3A = 2'h2;
  localparam logic [15:0] COEF_ONE = 16'h8000;
  localparam logic [15:0] COEF_3P3W = 16'h6ED9;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame layout and check byte
  localparam int CMD_WR_BIT = 7;
  localparam logic [4:0] EDGE_CMD_DONE = 5'h07;
  localparam logic [4:0] EDGE_ADDR_DONE = 5'h0F;
  localparam logic [4:0] EDGE_DATA_DONE = 5'h17;
  localparam logic [4:0] EDGE_CRC_DONE = 5'h1F;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

endpackage

// >>> momc_regs.sv
// Function
// - With the check byte enabled, every read frame ends with a CRC byte.
// - With the check byte enabled, a write commits only if its CRC matches.
// - Polarity clear: pulse pins idle high and go low for one width.
// - Polarity set: pulse pins idle low and go high for one width.
// - Harmonic auto-coefficient off: the host-loaded coefficient is used.
// - Fundamental auto-coefficient off: the host-written one is used.
// - Fundamental auto-coefficient on: it is derived from line frequency.
// - Fundamental disable stops fundamental work and raises the rate.
// - The wiring field picks the power coefficient 1 or sqrt(3)/2.
// - The apparent power is V times I, or the power vector length.
`timescale 1ns/1ps
`default_nettype none
module momc_regs
  import momc_pkg::*;
#(
  parameter int NPULSE = 2,
  parameter int PW_W = 16,
  parameter logic [15:0] FUND_GAIN = 16'h0100
)
(
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic sclk, // Serial clock
  input wire logic cs_n, // Serial select, active low
  input wire logic mosi, // Serial data in
  output logic miso, // Serial data out
  output logic miso_oe, // Serial data out enable
  input wire logic [NPULSE-1:0] pulse_event, // Pulse requests
  input wire logic [PW_W-1:0] pulse_width, // Pulse width in cycles
  output logic [NPULSE-1:0] pulse_pin, // Pulse outputs
  input wire logic [15:0] line_freq, // Measured line frequency
  input wire logic [4:0] harmonic_order_request, // Harmonic order
  input wire logic [15:0] harmonic_filter_coefficient, // Host value
  input wire logic [15:0] fundamental_filter_coefficient, // Host value
  input wire logic dsp_cycle, // Processing cycle strobe
  input wire logic [15:0] vrms, // RMS voltage
  input wire logic [15:0] irms, // RMS current
  input wire logic [31:0] vector_len, // Length of P,Q vector
  output logic [15:0] fund_coef, // Fundamental filter coefficient
  output logic [15:0] harm_coef, // Harmonic filter coefficient
  output logic [15:0] power_coef, // Wiring power coefficient
  output logic [1:0] wiring_mode, // Wiring system
  output logic fund_calc_en, // Fundamental work enabled
  output logic fast_rate_sel, // Higher rate for other results
  output logic harm_auto_en, // Harmonic coefficient computed here
  output logic [31:0] apparent_power, // Apparent power
  output logic crc_fault // Write rejected by check byte
);

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [7:0] snap1;
    logic [7:0] snap2;
    logic [NPULSE-1:0][PW_W-1:0] pw_cnt;
    logic [NPULSE-1:0] pulse_act;
    logic [NPULSE-1:0] pulse_pin;
    logic [15:0] fund_coef;
    logic [15:0] harm_coef;
    logic [15:0] power_coef;
    logic [1:0] wiring;
    logic fund_en;
    logic fast;
    logic harm_auto;
    logic [31:0] app;
    logic crc_fault;
  } momc_sys_t;

  momc_sys_t st;
  momc_sys_t next_st;

  logic lk_valid;
  logic lk_fail;
  logic [ADDR_W-1:0] lk_addr;
  logic [DATA_W-1:0] lk_data;

  ////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the serial clock
  momc_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .crc_en(st.snap1[OPM1_CRC_BIT]),
    .rd_op1(st.snap1),
    .rd_op2(st.snap2),
    .miso(miso),
    .miso_oe(miso_oe),
    .wr_valid(lk_valid),
    .crc_fail(lk_fail),
    .wr_addr(lk_addr),
    .wr_data(lk_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System side
  always_comb
  begin
    logic pol;
    logic fundamental_mode_disable;
    logic [31:0] fund_prod;
    logic [20:0] harm_prod;
    logic [PW_W-1:0] width;
    next_st = st;
    pol = st.op1[OPM1_POL_BIT];
    fundamental_mode_disable = st.op2[OPM2_FUN_BIT];
    fund_prod = line_freq * FUND_GAIN;
    harm_prod = line_freq * harmonic_order_request;
    width = (pulse_width == '0) ? PW_W'(1) : pulse_width;

    // Select edges; link results are still while the host keeps sclk idle
    next_st.cs_meta = cs_n;
    next_st.cs_sync = st.cs_meta;
    next_st.cs_prev = st.cs_sync;
    next_st.crc_fault = 1'b0;
    if (st.cs_prev && !st.cs_sync)
    begin
      next_st.snap1 = st.op1;
      next_st.snap2 = st.op2;
    end
    if (!st.cs_prev && st.cs_sync)
    begin
      next_st.crc_fault = lk_fail;
      if (lk_valid)
      begin
        case (lk_addr)
          OPM1_ADDR: next_st.op1 = lk_data & OPM1_MASK;
          OPM2_ADDR: next_st.op2 = lk_data & OPM2_MASK;
          default: next_st.op1 = st.op1;
        endcase
      end
    end

    // Pulse generators
    for (int i = 0; i < NPULSE; i++)
    begin
      if (st.pulse_act[i])
      begin
        if (st.pw_cnt[i] == PW_W'(1))
        begin
          next_st.pulse_act[i] = 1'b0;
        end
        next_st.pw_cnt[i] = st.pw_cnt[i] - PW_W'(1);
      end
      else if (pulse_event[i])
      begin
        next_st.pulse_act[i] = 1'b1;
        next_st.pw_cnt[i] = width;
      end
      next_st.pulse_pin[i] = pol ? next_st.pulse_act[i]
                                 : !next_st.pulse_act[i];
    end

    // Filter coefficients
    next_st.harm_auto = !st.op2[OPM2_HARM_BIT];
    if (st.op2[OPM2_HARM_BIT])
    begin
      next_st.harm_coef = harmonic_filter_coefficient;
    end
    else
    begin
      next_st.harm_coef = harm_prod[15:0];
    end
    if (fundamental_mode_disable)
    begin
      next_st.fund_coef = 16'h0000;
    end
    else if (st.op2[OPM2_FUNA_BIT])
    begin
      next_st.fund_coef = fundamental_filter_coefficient;
    end
    else
    begin
      next_st.fund_coef = fund_prod[23:8];
    end
    next_st.fund_en = !fundamental_mode_disable;
    next_st.fast = fundamental_mode_disable;

    // Wiring system
    next_st.wiring = st.op2[OPM2_WIR_MSB:OPM2_WIR_LSB];
    case (st.op2[OPM2_WIR_MSB:OPM2_WIR_LSB])
      WIR_3P3W: next_st.power_coef = COEF_3P3W;
      WIR_1P3W: next_st.power_coef = COEF_ONE;
      WIR_3V3A: next_st.power_coef = COEF_ONE;
      default: next_st.power_coef = COEF_ONE;
    endcase

    // Apparent power, once per processing cycle
    if (dsp_cycle)
    begin
      if (st.op2[OPM2_APP_BIT])
      begin
        next_st.app = vector_len;
      end
      else
      begin
        next_st.app = vrms * irms;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.cs_meta <= 1'b1;
      st.cs_sync <= 1'b1;
      st.cs_prev <= 1'b1;
      st.op1 <= OPM1_RESET;
      st.op2 <= OPM2_RESET;
      st.pulse_pin <= '1;
      st.power_coef <= COEF_ONE;
      st.fund_en <= 1'b1;
      st.harm_auto <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pulse_pin = st.pulse_pin;
  assign fund_coef = st.fund_coef;
  assign harm_coef = st.harm_coef;
  assign power_coef = st.power_coef;
  assign wiring_mode = st.wiring;
  assign fund_calc_en = st.fund_en;
  assign fast_rate_sel = st.fast;
  assign harm_auto_en = st.harm_auto;
  assign apparent_power = st.app;
  assign crc_fault = st.crc_fault;

endmodule
`default_nettype wire

// >>> momc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module momc_regs_monitor
  import momc_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic cs_n, // Select
  input wire logic miso_oe, // Out enable
  input wire logic [15:0] harmonic_filter_coefficient, // Host value
  input wire logic dsp_cycle, // Strobe
  input wire logic [15:0] fund_coef, // Fund coef
  input wire logic [15:0] harm_coef, // Harm coef
  input wire logic [15:0] power_coef, // Power coef
  input wire logic [1:0] wiring_mode, // Wiring
  input wire logic fund_calc_en, // Fund on
  input wire logic fast_rate_sel, // Fast rate
  input wire logic harm_auto_en, // Harm auto
  input wire logic [31:0] apparent_power, // Power
  input wire logic crc_fault // Fault
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_fund_rate_pair: assert property (fund_calc_en != fast_rate_sel)
    else $error("fund enable and rate select agree");
  a_fund_off_zero: assert property
    (fast_rate_sel |-> fund_coef == 16'h0000)
    else $error("fund coef not zero while disabled");
  a_coef_three_wire: assert property
    (wiring_mode == WIR_3P3W |-> power_coef == COEF_3P3W)
    else $error("power coef wrong for 3P3W");
  a_coef_unity: assert property
    (wiring_mode != WIR_3P3W |-> power_coef == COEF_ONE)
    else $error("power coef not one");
  a_harm_host_used: assert property
    (!harm_auto_en |-> harm_coef == $past(harmonic_filter_coefficient))
    else $error("harm coef not host value");
  a_app_power_hold: assert property
    (!$past(dsp_cycle) |-> $stable(apparent_power))
    else $error("apparent power moved off strobe");
  a_miso_idle_off: assert property (cs_n && $past(cs_n) |-> !miso_oe)
    else $error("miso driven outside frame");
  a_fault_one_cycle: assert property (crc_fault |=> !crc_fault)
    else $error("crc fault longer than one cycle");
  c_fault: cover property (crc_fault);
  c_fund_off: cover property (fast_rate_sel);
  c_three_wire: cover property (wiring_mode == WIR_3P3W);
endmodule
bind momc_regs momc_regs_monitor momc_regs_monitor_inst (.clk_sys, .rst_n,
  .cs_n, .miso_oe, .harmonic_filter_coefficient, .dsp_cycle, .fund_coef,
  .harm_coef, .power_coef, .wiring_mode, .fund_calc_en, .fast_rate_sel,
  .harm_auto_en, .apparent_power, .crc_fault);
`default_nettype wire

// >>> momc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module momc_regs_tb
  import momc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, cs_n, mosi, miso, miso_oe;
  logic [1:0] pulse_event = 2'b00;
  logic [15:0] pulse_width = 16'h0003;
  logic [1:0] pulse_pin;
  logic [15:0] line_freq = 16'h0032;
  logic [4:0] harmonic_order_request = 5'h03;
  logic [15:0] harmonic_filter_coefficient = 16'h1234;
  logic [15:0] fundamental_filter_coefficient = 16'h5678;
  logic dsp_cycle = 1'b0;
  logic [15:0] vrms = 16'h0100;
  logic [15:0] irms = 16'h0020;
  logic [31:0] vector_len = 32'h00012345;
  logic [15:0] fund_coef, harm_coef, power_coef;
  logic [1:0] wiring_mode;
  logic fund_calc_en, fast_rate_sel, harm_auto_en, crc_fault;
  logic [31:0] apparent_power;
  int errors = 0;
  int n_compared = 0;
  int faults = 0;
  always #12.5 clk_sys = ~clk_sys;
  momc_host momc_host_inst (.sclk, .cs_n, .mosi, .miso);
  momc_regs momc_regs_inst (.clk_sys, .rst_n, .sclk, .cs_n, .mosi, .miso,
    .miso_oe, .pulse_event, .pulse_width, .pulse_pin, .line_freq,
    .harmonic_order_request, .harmonic_filter_coefficient,
    .fundamental_filter_coefficient, .dsp_cycle, .vrms, .irms, .vector_len,
    .fund_coef, .harm_coef, .power_coef, .wiring_mode, .fund_calc_en,
    .fast_rate_sel, .harm_auto_en, .apparent_power, .crc_fault);
  always @(posedge clk_sys)
    if (crc_fault === 1'b1)
      faults++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
    input logic c, input logic bad);
    logic [7:0] x, y;
    momc_host_inst.xfer({4'h8, a, d}, c,
      momc_host_inst.crc8({4'h8, a, d}) ^ {7'h00, bad}, x, y);
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic c, input logic [7:0] e);
    logic [7:0] x, y;
    momc_host_inst.xfer({4'h0, a, 8'h00}, c, 8'h00, x, y);
    chk(x, e);
    if (c)
      chk(y, momc_host_inst.crc8({4'h0, a, e}));
  endtask
  task automatic dsp(input logic [31:0] e);
    @(posedge clk_sys);
    dsp_cycle <= 1'b1;
    @(posedge clk_sys);
    dsp_cycle <= 1'b0;
    @(negedge clk_sys);
    chk(apparent_power, e);
  endtask
  task automatic pulse(input logic act);
    int n;
    n = 0;
    chk(pulse_pin, {2{~act}});
    @(posedge clk_sys);
    pulse_event <= 2'b11;
    @(posedge clk_sys);
    pulse_event <= 2'b00;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_sys);
      if (pulse_pin === {2{act}})
        n++;
    end
    chk(n, 3);
    chk(pulse_pin, {2{~act}});
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #2ms;
    errors++;
    finish_test();
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk_sys);
    chk(pulse_pin, 2'b11);
    chk({power_coef, fund_calc_en}, {COEF_ONE, 1'b1});
    rd(OPM1_ADDR, 1'b0, OPM1_RESET);
    rd(OPM2_ADDR, 1'b0, OPM2_RESET);
    $display("test reset done");
    wr(OPM2_ADDR, 8'hFF, 1'b0, 1'b0);
    rd(OPM2_ADDR, 1'b0, OPM2_MASK);
    chk({wiring_mode, fast_rate_sel, fund_coef}, {2'h3, 1'b1, 16'h0});
    chk({harm_auto_en, harm_coef}, {1'b0, 16'h1234});
    dsp(vector_len);
    wr(OPM2_ADDR, 8'h22, 1'b0, 1'b0);
    chk({power_coef, fund_calc_en}, {COEF_3P3W, 1'b1});
    chk(fund_coef, 16'h5678);
    wr(OPM2_ADDR, 8'h04, 1'b0, 1'b0);
    chk({wiring_mode, power_coef}, {WIR_3V3A, COEF_ONE});
    wr(OPM2_ADDR, 8'h00, 1'b0, 1'b0);
    chk({fund_coef, harm_coef}, {16'h0032, 16'h0096});
    dsp(32'h00002000);
    $display("test modes done");
    pulse(1'b0);
    wr(OPM1_ADDR, 8'h04, 1'b0, 1'b0);
    pulse(1'b1);
    $display("test pulses done");
    wr(OPM1_ADDR, 8'hFF, 1'b0, 1'b0);
    rd(OPM1_ADDR, 1'b1, OPM1_MASK);
    wr(OPM2_ADDR, 8'h11, 1'b1, 1'b1);
    chk(faults, 1);
    rd(OPM2_ADDR, 1'b1, 8'h00);
    wr(OPM2_ADDR, 8'h11, 1'b1, 1'b0);
    rd(OPM2_ADDR, 1'b1, 8'h11);
    rd(12'h005, 1'b1, 8'h00);
    chk(faults, 1);
    $display("test check byte done");
    finish_test();
  end
endmodule
`default_nettype wire
